// File: logic/rspl_loader.sv
// reset merge, strap capture and serial rom configuration loader
`timescale 1ns/1ps
`default_nettype none
// Function
// - four reset sources reinitialise the sequence, reader and counters; the watchdog flag and rom registers keep their values
// - shared buses released during reset
// - strap captured at reset pin rising edge
// - bus drivers re-enabled after capture
// - fourteen-bit identifier excludes top subaddress bits
// - mode bits: serial-off and test, default zero
// - serial-off mode stops secondary channel decoding
// - rom pin tristated, sampled at reset release
// - rom contents overwrite the strapped identifier
// - exactly eighty rom bits, ten registers
// - rom bits lsb first, register 0 upward
// - rom reset pulse is active high
// - lock-loss watchdog triggers automatic reset
// - watchdog reset sets status bit four
// - status write of zero clears flag
// - status write of five starts reset
// - rom pin drives rom reset after reset
module rspl_loader
  import rspl_pkg::*;
#(
  parameter int WDOG_CYCLES      = WDOG_TIMEOUT_CYC,
  parameter int ROM_CLEAR_CYCLES = ROM_RESET_CYCLES
)(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // reset sources
  input  wire logic                 reset_pin_n,
  input  wire logic                 link_reset_cmd,
  input  wire logic                 status_wr,
  input  wire logic [7:0]           status_wr_data,
  input  wire logic                 cdr_locked,
  // normal output values of the shared buses
  input  wire logic [7:0]           subaddress_src,
  input  wire logic [7:0]           data_src,
  // shared subaddress bus pins
  input  wire logic [7:0]           subaddress_in,
  output logic      [7:0]           subaddress_out_bus,
  output logic                      subaddress_oe,
  // shared data bus pins
  input  wire logic [7:0]           data_in,
  output logic      [7:0]           data_out,
  output logic                      data_oe,
  // rom enable / rom clear pin
  input  wire logic                 loader_enable_rom_clear_pin_in,
  output logic                      loader_enable_rom_clear_pin_out,
  output logic                      loader_enable_rom_clear_pin_oe,
  // rom serial pins
  output logic                      rom_clk,
  input  wire logic                 rom_data,
  // configuration and status
  output logic                      internal_reset,
  output logic [ID_WIDTH-1:0]       chip_identifier,
  output logic [1:0]                operating_strap_bits,
  output logic                      serial_conversion_off,
  output logic                      test_mode,
  output logic                      secondary_decode_en,
  output logic                      rom_load_enabled,
  output logic                      config_ready,
  output logic [7:0]                status_out,
  output logic [8*CFG_REGS-1:0]     config_regs
);

  rspl_state_t state_reg;
  logic [15:0] hold_cnt_reg;
  logic [15:0] clr_cnt_reg;
  logic [31:0] wdog_cnt_reg;
  logic [6:0]  bit_idx_reg;
  logic [7:0]  cfg_reg [CFG_REGS];
  logic        wdog_flag_reg;
  logic        reader_start_reg;
  logic        reader_done;
  logic        bit_valid;
  logic        bit_value;
  logic        wdog_fire;
  logic        soft_reset;
  logic        reset_req;
  logic        leave_hold;

  // ----------------------------------------------------------------
  // reset merge
  // ----------------------------------------------------------------
  assign wdog_fire  = (state_reg == ST_RUN) && !cdr_locked &&
                      (wdog_cnt_reg == 32'(WDOG_CYCLES - 1));
  assign soft_reset = status_wr && (status_wr_data == STATUS_CMD_RESET);
  assign reset_req  = link_reset_cmd || soft_reset || wdog_fire;
  // the pin holds reset by itself; release happens on the first high sample
  assign leave_hold = (state_reg == ST_HOLD) && reset_pin_n && !reset_req &&
                      (hold_cnt_reg == 16'(INT_RESET_CYCLES));

  // internal sources get a fixed pulse; the pin keeps the count full so
  // that release coincides exactly with its rising edge
  always_ff @(posedge mclk) begin
    if (srst || reset_req) begin
      hold_cnt_reg <= 16'h0000;
    end else if (!reset_pin_n) begin
      hold_cnt_reg <= 16'(INT_RESET_CYCLES);
    end else if (hold_cnt_reg != 16'(INT_RESET_CYCLES)) begin
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    reader_start_reg <= 1'b0;
    if (srst || reset_req || !reset_pin_n) begin
      state_reg <= ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (leave_hold) begin
            state_reg <= loader_enable_rom_clear_pin_in ? ST_ROM_CLR : ST_RUN;
          end
        end
        ST_ROM_CLR: begin
          if (clr_cnt_reg == 16'(ROM_CLEAR_CYCLES - 1)) begin
            state_reg        <= ST_ROM_LOAD;
            reader_start_reg <= 1'b1;
          end
        end
        ST_ROM_LOAD: begin
          if (reader_done) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (state_reg == ST_ROM_CLR) begin
      clr_cnt_reg <= clr_cnt_reg + 16'h0001;
    end else begin
      clr_cnt_reg <= 16'h0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      internal_reset <= 1'b1;
      config_ready   <= 1'b0;
    end else begin
      internal_reset <= (state_reg == ST_HOLD) && !leave_hold;
      config_ready   <= (state_reg == ST_RUN) && !reset_req && reset_pin_n;
    end
  end

  // ----------------------------------------------------------------
  // shared buses and strap capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      subaddress_oe      <= 1'b0;
      data_oe            <= 1'b0;
      subaddress_out_bus <= 8'h00;
      data_out           <= 8'h00;
    end else begin
      subaddress_oe      <= (state_reg != ST_HOLD) || leave_hold;
      data_oe            <= (state_reg != ST_HOLD) || leave_hold;
      subaddress_out_bus <= subaddress_src;
      data_out           <= data_src;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      operating_strap_bits <= MODE_RESET_VALUE;
      rom_load_enabled     <= 1'b0;
    end else if (leave_hold) begin
      operating_strap_bits <= subaddress_in[7:6];
      rom_load_enabled     <= loader_enable_rom_clear_pin_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      chip_identifier <= '0;
    end else if (leave_hold) begin
      chip_identifier <= {subaddress_in[5:0], data_in};
    end else if (reader_done) begin
      chip_identifier <= {cfg_reg[ID_HI_INDEX][5:0], cfg_reg[ID_LO_INDEX]};
    end
  end

  // serial-off mode turns the secondary channel into a plain serial feed
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_conversion_off <= 1'b0;
      test_mode             <= 1'b0;
      secondary_decode_en   <= 1'b0;
    end else begin
      serial_conversion_off <= operating_strap_bits[MODE_SERIAL_OFF];
      test_mode             <= operating_strap_bits[MODE_TEST];
      secondary_decode_en   <= !operating_strap_bits[MODE_SERIAL_OFF] &&
                               (state_reg == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // rom pin and rom read
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      loader_enable_rom_clear_pin_oe  <= 1'b0;
      loader_enable_rom_clear_pin_out <= 1'b0;
    end else begin
      loader_enable_rom_clear_pin_oe  <= (state_reg != ST_HOLD) || leave_hold;
      loader_enable_rom_clear_pin_out <= (state_reg == ST_ROM_CLR &&
                                          clr_cnt_reg != 16'(ROM_CLEAR_CYCLES - 1)) ||
                                         (leave_hold && loader_enable_rom_clear_pin_in);
    end
  end

  rspl_rom_reader u_reader (
    .mclk      (mclk),
    .srst      (srst || state_reg == ST_HOLD),
    .start     (reader_start_reg),
    .done      (reader_done),
    .rom_clk   (rom_clk),
    .rom_data  (rom_data),
    .bit_valid (bit_valid),
    .bit_value (bit_value)
  );

  // rom bits fill the registers bit by bit; the strapped identifier is replaced when the read is done
  always_ff @(posedge mclk) begin
    if (srst || state_reg == ST_HOLD) begin
      bit_idx_reg <= 7'h00;
    end else if (bit_valid && state_reg == ST_ROM_LOAD) begin
      cfg_reg[bit_idx_reg[6:3]][bit_idx_reg[2:0]] <= bit_value;
      bit_idx_reg <= bit_idx_reg + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < CFG_REGS; i++) begin
      config_regs[8*i +: 8] <= cfg_reg[i];
    end
  end

  // ----------------------------------------------------------------
  // watchdog and status
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || state_reg != ST_RUN || cdr_locked) begin
      wdog_cnt_reg <= 32'h0000_0000;
    end else if (!wdog_fire) begin
      wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
    end
  end

  // set wins over a same-cycle clear; the flag outlives the reset it reports
  always_ff @(posedge mclk) begin
    if (srst) begin
      wdog_flag_reg <= 1'b0;
    end else if (wdog_fire) begin
      wdog_flag_reg <= 1'b1;
    end else if (status_wr && status_wr_data == STATUS_CMD_CLEAR) begin
      wdog_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      status_out <= 8'h00;
    end else begin
      status_out                  <= 8'h00;
      status_out[STATUS_WDOG_BIT] <= wdog_flag_reg;
    end
  end

endmodule : rspl_loader
`default_nettype wire

// File: logic/rspl_pkg.sv
// constants shared by the reset, strap and configuration loader
package rspl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 8;
  localparam int INT_RESET_NS     = 2000;
  localparam int INT_RESET_CYCLES = (INT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROM_RESET_NS     = 1000;
  localparam int ROM_RESET_CYCLES = (ROM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROM_CLK_HALF_NS  = 40;
  localparam int ROM_CLK_HALF_CYC = (ROM_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_TIMEOUT_CYC = 1000000;

  // ----------------------------------------------------------------
  // serial rom layout
  // ----------------------------------------------------------------
  localparam int       ROM_BITS     = 80;
  localparam int       CFG_REGS     = 10;
  localparam logic [3:0] ID_LO_INDEX = 4'h6;
  localparam logic [3:0] ID_HI_INDEX = 4'h7;

  // ----------------------------------------------------------------
  // strap layout and status register
  // ----------------------------------------------------------------
  localparam int         ID_WIDTH          = 14;
  localparam int         MODE_SERIAL_OFF   = 0;
  localparam int         MODE_TEST         = 1;
  localparam logic [1:0] MODE_RESET_VALUE  = 2'h0;
  localparam int         STATUS_WDOG_BIT   = 4;
  localparam logic [7:0] STATUS_CMD_CLEAR  = 8'h00;
  localparam logic [7:0] STATUS_CMD_RESET  = 8'h05;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_ROM_CLR,
    ST_ROM_LOAD,
    ST_RUN
  } rspl_state_t;

endpackage : rspl_pkg

// File: logic/rspl_rom_reader.sv
// serial configuration rom bit reader
`timescale 1ns/1ps
`default_nettype none
module rspl_rom_reader
  import rspl_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // control
  input  wire logic start,
  output logic      done,
  // rom pins
  output logic      rom_clk,
  input  wire logic rom_data,
  // received bits
  output logic      bit_valid,
  output logic      bit_value
);

  logic [7:0] div_reg;
  logic [6:0] bit_cnt_reg;
  logic       active_reg;

  // ----------------------------------------------------------------
  // clock divider and bit counter
  // ----------------------------------------------------------------
  // data is taken at the end of the low phase, one full period after
  // the previous rising edge, so the rom output has settled
  always_ff @(posedge mclk) begin
    bit_valid <= 1'b0;
    done      <= 1'b0;
    if (srst) begin
      div_reg     <= 8'h00;
      bit_cnt_reg <= 7'h00;
      active_reg  <= 1'b0;
      rom_clk     <= 1'b0;
      bit_value   <= 1'b0;
    end else if (start) begin
      div_reg     <= 8'h00;
      bit_cnt_reg <= 7'h00;
      active_reg  <= 1'b1;
      rom_clk     <= 1'b0;
    end else if (active_reg) begin
      if (div_reg == 8'(ROM_CLK_HALF_CYC - 1)) begin
        div_reg <= 8'h00;
        rom_clk <= ~rom_clk;
        if (!rom_clk) begin
          bit_valid   <= 1'b1;
          bit_value   <= rom_data;
          bit_cnt_reg <= bit_cnt_reg + 7'h01;
          if (bit_cnt_reg == 7'(ROM_BITS - 1)) begin
            active_reg <= 1'b0;
            rom_clk    <= 1'b0;
            done       <= 1'b1;
          end
        end
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

endmodule : rspl_rom_reader
`default_nettype wire

// File: tb/rspl_board_model.sv
// board strap resistors and serial configuration rom
`timescale 1ns/1ps
`default_nettype none
module rspl_board_model (
  // board setup
  input  wire logic [15:0] strap,
  input  wire logic        rom_on,
  input  wire logic [79:0] image,
  // shared pins
  input  wire logic [7:0]  sa_o,
  input  wire logic        sa_oe,
  input  wire logic [7:0]  d_o,
  input  wire logic        d_oe,
  output logic      [7:0]  sa_i,
  output logic      [7:0]  d_i,
  input  wire logic        en_o,
  input  wire logic        en_oe,
  output logic             en_i,
  // rom serial pins
  input  wire logic        rclk,
  output logic             rdat
);
  // ----------------------------------------------------------------
  // resistors set the level only while the chip lets go
  // ----------------------------------------------------------------
  assign sa_i = sa_oe ? sa_o : strap[15:8];
  assign d_i  = d_oe ? d_o : strap[7:0];
  assign en_i = en_oe ? en_o : rom_on;
  // ----------------------------------------------------------------
  // rom: address cleared while the shared pin is high
  // ----------------------------------------------------------------
  logic [6:0] idx;
  always_ff @(posedge rclk or posedge en_i) begin
    if (en_i) idx <= 7'h00;
    else if (idx < 7'h50) idx <= idx + 7'h01;
  end
  // no rom or past the image: the line floats, so show a changing level
  assign rdat = (rom_on && !en_i && idx < 7'h50) ? image[idx] : ~idx[0];
endmodule : rspl_board_model
`default_nettype wire

// File: tb/rspl_loader_props.sv
// assertion checker for the reset, strap and rom loader
`timescale 1ns/1ps
`default_nettype none
module rspl_loader_props
  import rspl_pkg::*;
#(
  parameter int WDOG_CYCLES      = 50,
  parameter int ROM_CLEAR_CYCLES = 4
)(
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  srst,
  // reset sources
  input wire logic                  reset_pin_n,
  input wire logic                  link_reset_cmd,
  input wire logic                  status_wr,
  input wire logic [7:0]            status_wr_data,
  input wire logic                  cdr_locked,
  // pins
  input wire logic [7:0]            subaddress_in,
  input wire logic                  subaddress_oe,
  input wire logic [7:0]            data_in,
  input wire logic                  data_oe,
  input wire logic                  loader_enable_rom_clear_pin_in,
  input wire logic                  loader_enable_rom_clear_pin_out,
  input wire logic                  loader_enable_rom_clear_pin_oe,
  // configuration and status
  input wire logic                  internal_reset,
  input wire logic [ID_WIDTH-1:0]   chip_identifier,
  input wire logic [1:0]            operating_strap_bits,
  input wire logic                  rom_load_enabled,
  input wire logic                  config_ready,
  input wire logic [7:0]            status_out,
  input wire logic [8*CFG_REGS-1:0] config_regs
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  int clr_cnt;
  int lost_cnt;
  always_ff @(posedge mclk) begin
    if (srst || !loader_enable_rom_clear_pin_out) clr_cnt <= 0;
    else clr_cnt <= clr_cnt + 1;
  end
  // only lock loss seen while running counts, as the watchdog sleeps in reset
  always_ff @(posedge mclk) begin
    if (srst || cdr_locked || !config_ready) lost_cnt <= 0;
    else if (lost_cnt < WDOG_CYCLES) lost_cnt <= lost_cnt + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_release;
    $fell(internal_reset);
  endsequence
  sequence s_rom_done;
    $rose(config_ready) && rom_load_enabled;
  endsequence
  a_bus_released: assert property (internal_reset && $past(internal_reset) |->
    !subaddress_oe && !data_oe && !loader_enable_rom_clear_pin_oe)
    else $error("pins driven in reset");
  a_drivers_back: assert property (s_release |->
    subaddress_oe && data_oe && loader_enable_rom_clear_pin_oe) else $error("drivers still off");
  // pins are driven again once released, so the strap is the level one cycle back
  a_strap_capture: assert property (s_release |->
    chip_identifier == {$past(subaddress_in[5:0]), $past(data_in)}
    && operating_strap_bits == $past(subaddress_in[7:6])
    && rom_load_enabled == $past(loader_enable_rom_clear_pin_in))
    else $error("strap not captured");
  a_clear_width: assert property ($fell(loader_enable_rom_clear_pin_out) |->
    clr_cnt == ROM_CLEAR_CYCLES) else $error("rom clear pulse width wrong");
  a_rom_id: assert property (s_rom_done |->
    chip_identifier == {config_regs[61:56], config_regs[55:48]}) else $error("id not from rom");
  a_pin_reset: assert property (!reset_pin_n |-> ##[1:3] internal_reset)
    else $error("pin reset missed");
  a_link_reset: assert property (link_reset_cmd |-> ##[1:3] internal_reset)
    else $error("link reset missed");
  a_write_reset: assert property (status_wr && status_wr_data == STATUS_CMD_RESET |->
    ##[1:3] internal_reset) else $error("status reset missed");
  // the status byte is registered from the flag, hence two edges
  a_flag_clear: assert property (status_wr && status_wr_data == STATUS_CMD_CLEAR
    && cdr_locked |-> ##2 !status_out[STATUS_WDOG_BIT]) else $error("flag not cleared");
  a_wdog_fire: assert property (lost_cnt == WDOG_CYCLES |-> ##[0:3] internal_reset)
    else $error("watchdog did not fire");
endmodule : rspl_loader_props
bind rspl_loader rspl_loader_props #(.WDOG_CYCLES(WDOG_CYCLES), .ROM_CLEAR_CYCLES(ROM_CLEAR_CYCLES))
  u_props (.mclk, .srst, .reset_pin_n, .link_reset_cmd, .status_wr, .status_wr_data, .cdr_locked,
  .subaddress_in, .subaddress_oe, .data_in, .data_oe, .loader_enable_rom_clear_pin_in,
  .loader_enable_rom_clear_pin_out, .loader_enable_rom_clear_pin_oe, .internal_reset,
  .chip_identifier, .operating_strap_bits, .rom_load_enabled, .config_ready, .status_out,
  .config_regs);
`default_nettype wire

// File: tb/rspl_loader_tb.sv
// self-checking bench for the reset, strap and rom loader
`timescale 1ns/1ps
`default_nettype none
module rspl_loader_tb;
  import rspl_pkg::*;
  localparam int WD = 50;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                mclk, srst, reset_pin_n, link_reset_cmd, status_wr, cdr_locked;
  logic [7:0]          status_wr_data, subaddress_src, data_src, subaddress_in, data_in;
  logic [7:0]          subaddress_out_bus, data_out, status_out;
  logic                subaddress_oe, data_oe, en_i, en_o, en_oe, rom_clk, rom_data, rom_on;
  logic                internal_reset, serial_conversion_off, test_mode, secondary_decode_en;
  logic                rom_load_enabled, config_ready;
  logic [ID_WIDTH-1:0] chip_identifier;
  logic [1:0]          operating_strap_bits;
  logic [79:0]         config_regs, img;
  logic [15:0]         strap, s;
  logic [31:0]         v;
  int                  miscompares, samples_checked, seed;
  rspl_loader #(.WDOG_CYCLES(WD), .ROM_CLEAR_CYCLES(4)) uut (.mclk, .srst, .reset_pin_n,
    .link_reset_cmd, .status_wr, .status_wr_data, .cdr_locked, .subaddress_src, .data_src,
    .subaddress_in, .subaddress_out_bus, .subaddress_oe, .data_in, .data_out, .data_oe,
    .loader_enable_rom_clear_pin_in(en_i), .loader_enable_rom_clear_pin_out(en_o),
    .loader_enable_rom_clear_pin_oe(en_oe), .rom_clk, .rom_data, .internal_reset,
    .chip_identifier, .operating_strap_bits, .serial_conversion_off, .test_mode,
    .secondary_decode_en, .rom_load_enabled, .config_ready, .status_out, .config_regs);
  rspl_board_model board (.strap, .rom_on, .image(img), .sa_o(subaddress_out_bus),
    .sa_oe(subaddress_oe), .d_o(data_out), .d_oe(data_oe), .sa_i(subaddress_in),
    .d_i(data_in), .en_o, .en_oe, .en_i, .rclk(rom_clk), .rdat(rom_data));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk_v(input logic [79:0] g, input logic [79:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk_v
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tk
  // bounded wait, since a stuck loader must not hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (config_ready !== 1'b1 && n < 3000) begin
      tk(1);
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask : wait_ready
  task automatic wr(input logic [7:0] d);
    @(posedge mclk);
    status_wr <= 1'b1;
    status_wr_data <= d;
    @(posedge mclk) status_wr <= 1'b0;
    tk(3);
  endtask : wr
  function automatic logic [13:0] exp_id(input logic [15:0] t, input logic r, input logic [79:0] m);
    return r ? {m[61:56], m[55:48]} : t[13:0];
  endfunction : exp_id
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {srst, reset_pin_n, cdr_locked} = 3'h7;
    {link_reset_cmd, status_wr, status_wr_data, subaddress_src, data_src} = 26'h0;
    {strap, rom_on, img} = 97'h0;
    {miscompares, samples_checked} = 64'h0;
    seed = $urandom(9);
    tk(9);
    @(posedge mclk) srst <= 1'b0;
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      s = 16'($urandom);
      if (i == 0) s[15:14] = 2'h0;
      if (i == 1) s[15:14] = 2'h3;
      @(posedge mclk);
      strap <= s;
      rom_on <= i[1];
      img <= {$urandom, $urandom, 16'($urandom)};
      reset_pin_n <= 1'b0;
      tk(20);
      chk_v({subaddress_oe, data_oe, en_oe}, 80'h0);
      @(posedge mclk) reset_pin_n <= 1'b1;
      wait_ready();
      chk_v(operating_strap_bits, s[15:14]);
      chk_v({serial_conversion_off, test_mode, secondary_decode_en},
            {s[14], s[15], !s[14]});
      chk_v(rom_load_enabled, i[1]);
      chk_v(chip_identifier, exp_id(s, i[1], img));
      if (i[1]) chk_v(config_regs, img);
      v = $urandom;
      @(posedge mclk);
      subaddress_src <= v[15:8];
      data_src <= v[7:0];
      tk(2);
      chk_v({subaddress_in, data_in}, v[15:0]);
    end
    @(posedge mclk) link_reset_cmd <= 1'b1;
    @(posedge mclk) link_reset_cmd <= 1'b0;
    tk(3);
    chk_v(internal_reset, 1'b1);
    wait_ready();
    wr(8'h03);
    chk_v(internal_reset, 1'b0);
    wr(STATUS_CMD_RESET);
    chk_v(internal_reset, 1'b1);
    wait_ready();
    chk_v(status_out, 8'h00);
    @(posedge mclk) cdr_locked <= 1'b0;
    tk(WD + 10);
    chk_v(internal_reset, 1'b1);
    @(posedge mclk) cdr_locked <= 1'b1;
    wait_ready();
    chk_v(status_out, 8'h01 << STATUS_WDOG_BIT);
    wr(8'h03);
    chk_v(status_out, 8'h01 << STATUS_WDOG_BIT);
    wr(STATUS_CMD_CLEAR);
    chk_v(status_out, 8'h00);
    wrap_up();
  end
endmodule : rspl_loader_tb
`default_nettype wire
